//--- logic/pbmr_map.svh
`ifndef PBMR_MAP_SVH
`define PBMR_MAP_SVH
// register indices
`define PBMR_IDX_CTRL      5'h00
`define PBMR_IDX_STAT      5'h01
`define PBMR_IDX_ID_HI     5'h02
`define PBMR_IDX_ID_LO     5'h03
`define PBMR_IDX_ADV       5'h04
// control bit positions
`define PBMR_CTRL_RST_BIT  15
`define PBMR_CTRL_LOOP_BIT 14
`define PBMR_CTRL_SPD_BIT  13
`define PBMR_CTRL_AN_BIT   12
`define PBMR_CTRL_PDN_BIT  11
`define PBMR_CTRL_ANRS_BIT 9
`define PBMR_CTRL_DUP_BIT  8
`define PBMR_CTRL_COLT_BIT 7
`define PBMR_CTRL_WMASK    16'h7980
`define PBMR_CTRL_RESET    16'h3000
// status bit positions and fixed part
`define PBMR_STAT_ANC_BIT  5
`define PBMR_STAT_RF_BIT   4
`define PBMR_STAT_LINK_BIT 2
`define PBMR_STAT_JAB_BIT  1
`define PBMR_STAT_FMASK    16'hf809
`define PBMR_STAT_FIXED    16'h7809
// advertisement
`define PBMR_ADV_WMASK     16'hbfff
`define PBMR_ADV_RESET     16'h01e1
// identifier field positions
`define PBMR_ID_OUI_LSB    10
`define PBMR_ID_MODEL_LSB  4
`endif

//--- logic/pbmr_pkg.sv
package pbmr_pkg;
    typedef logic [15:0] pbmr_word_t;
    typedef logic [4:0]  pbmr_index_t;
endpackage

//--- logic/pbmr_acc_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pbmr_acc_if;
    import pbmr_pkg::*;
    logic        wr;
    logic        rd_stat;
    logic        sreset;
    pbmr_index_t index;
    pbmr_word_t  wdata;
    logic        link_in;
    logic        rf_in;
    logic        jab_in;
    logic        anc_in;
    logic        link_lat;
    logic        rf_lat;
    logic        jab_lat;
    logic        anc_q;
    pbmr_word_t  id_hi;
    pbmr_word_t  id_lo;
    modport top_mp (output wr, rd_stat, sreset, index, wdata, link_in, rf_in, jab_in, anc_in,
                    input link_lat, rf_lat, jab_lat, anc_q, id_hi, id_lo);
    modport lat_mp (input rd_stat, sreset, link_in, rf_in, jab_in, anc_in,
                    output link_lat, rf_lat, jab_lat, anc_q);
    modport id_mp  (input wr, index, wdata, output id_hi, id_lo);
endinterface
`default_nettype wire

//--- logic/pbmr_latch.sv
`timescale 1ns/100ps
`default_nettype none
`include "pbmr_map.svh"
module pbmr_latch
    import pbmr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    pbmr_acc_if.lat_mp acc
);
    logic link_r, rf_r, jab_r, anc_r;
    logic link_nxt, rf_nxt, jab_nxt, anc_nxt;

    // fault set wins over read clear; a low link input wins over the read re-arm
    always_comb begin
        link_nxt = acc.link_in & (link_r | acc.rd_stat | acc.sreset);
        rf_nxt   = acc.rf_in | (rf_r & ~acc.rd_stat & ~acc.sreset);
        jab_nxt  = acc.jab_in | (jab_r & ~acc.rd_stat & ~acc.sreset);
        anc_nxt  = acc.anc_in;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link_r <= 1'b0;
            rf_r   <= 1'b0;
            jab_r  <= 1'b0;
            anc_r  <= 1'b0;
        end else begin
            link_r <= link_nxt;
            rf_r   <= rf_nxt;
            jab_r  <= jab_nxt;
            anc_r  <= anc_nxt;
        end
    end

    assign acc.link_lat = link_r;
    assign acc.rf_lat   = rf_r;
    assign acc.jab_lat  = jab_r;
    assign acc.anc_q    = anc_r;

    a_link_low_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !acc.link_lat && !acc.rd_stat && !acc.sreset |=> !acc.link_lat)
        else $error("link latch rose without a status read");
    a_rf_latch_high: assert property (@(posedge clk) disable iff (!rst_n)
        acc.rf_in ##1 (!acc.rd_stat && !acc.sreset) [*2] |=> acc.rf_lat)
        else $error("remote fault latch lost before read");
    a_jab_latch_high: assert property (@(posedge clk) disable iff (!rst_n)
        acc.jab_in |=> acc.jab_lat)
        else $error("jabber latch did not set");
endmodule
`default_nettype wire

//--- logic/pbmr_ident.sv
`timescale 1ns/100ps
`default_nettype none
`include "pbmr_map.svh"
module pbmr_ident
    import pbmr_pkg::*;
#(
    // identifier defaults are arbitrary values
    parameter logic [15:0] OUI_HI = 16'h1234,
    parameter logic [5:0]  OUI_LO = 6'h2a,
    parameter logic [5:0]  MODEL  = 6'h05,
    parameter logic [3:0]  REV    = 4'h1
)(
    input  wire logic clk,
    input  wire logic rst_n,
    pbmr_acc_if.id_mp acc
);
    localparam pbmr_word_t ID_LO_RST = {OUI_LO, MODEL, REV};
    pbmr_word_t hi_r, lo_r, hi_nxt, lo_nxt;

    // no soft reset term here: kept over soft reset
    always_comb begin
        hi_nxt = hi_r;
        lo_nxt = lo_r;
        if (acc.wr && acc.index == `PBMR_IDX_ID_HI) begin
            hi_nxt = acc.wdata;
        end
        if (acc.wr && acc.index == `PBMR_IDX_ID_LO) begin
            lo_nxt = acc.wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_r <= OUI_HI;
            lo_r <= ID_LO_RST;
        end else begin
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
        end
    end

    assign acc.id_hi = hi_r;
    assign acc.id_lo = lo_r;

    a_id_kept_stable: assert property (@(posedge clk) disable iff (!rst_n)
        !acc.wr |=> $stable(hi_r) && $stable(lo_r))
        else $error("identifier changed without a write");
endmodule
`default_nettype wire

//--- logic/phy_basic_management_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "pbmr_map.svh"
module phy_basic_management_regs
    import pbmr_pkg::*;
#(
    // identifier defaults are arbitrary values
    parameter logic [15:0] OUI_HI = 16'h1234,
    parameter logic [5:0]  OUI_LO = 6'h2a,
    parameter logic [5:0]  MODEL  = 6'h05,
    parameter logic [3:0]  REV    = 4'h1
)(
    // clock and reset
    input  wire logic        I_MCLK,
    input  wire logic        I_RST_N,
    // management access by index
    input  wire logic [4:0]  I_REG_INDEX,
    input  wire logic        I_REG_WR,
    input  wire logic        I_REG_RD,
    input  wire logic [15:0] I_REG_WDATA,
    output var  logic [15:0] O_REG_RDATA,
    output var  logic        O_REG_RVALID,
    // line state from the transceiver
    input  wire logic        I_LINK_UP,
    input  wire logic        I_AN_DONE,
    input  wire logic        I_REMOTE_FAULT,
    input  wire logic        I_JABBER,
    input  wire logic        I_AN_SPEED_100,
    input  wire logic        I_AN_FULL_DUPLEX,
    // controls to the transceiver
    output var  logic        O_SOFT_RESET,
    output var  logic        O_LOOPBACK,
    output var  logic        O_SPEED_100,
    output var  logic        O_FULL_DUPLEX,
    output var  logic        O_AN_ENABLE,
    output var  logic        O_AN_RESTART,
    output var  logic        O_POWER_DOWN,
    output var  logic        O_COL_TEST,
    output var  logic [15:0] O_ADVERT
);
    function automatic logic hit(input logic strobe, input pbmr_index_t idx,
                                 input pbmr_index_t want);
        return strobe && (idx == want);
    endfunction

    pbmr_acc_if acc ();

    pbmr_word_t ctrl_r, ctrl_nxt;
    pbmr_word_t adv_r, adv_nxt;
    pbmr_word_t rdata_r, rdata_nxt;
    pbmr_word_t stat_word;
    logic       rvalid_r, rvalid_nxt;
    logic       srst_r, srst_nxt;
    logic       anrs_r, anrs_nxt;
    logic       spd_r, spd_nxt;
    logic       dup_r, dup_nxt;
    logic       wr_ctrl, wr_adv;

    assign wr_ctrl = hit(I_REG_WR, I_REG_INDEX, `PBMR_IDX_CTRL);
    assign wr_adv  = hit(I_REG_WR, I_REG_INDEX, `PBMR_IDX_ADV);

    assign acc.wr      = I_REG_WR;
    assign acc.index   = I_REG_INDEX;
    assign acc.wdata   = I_REG_WDATA;
    assign acc.rd_stat = hit(I_REG_RD, I_REG_INDEX, `PBMR_IDX_STAT);
    assign acc.sreset  = srst_r;
    assign acc.link_in = I_LINK_UP;
    assign acc.rf_in   = I_REMOTE_FAULT;
    assign acc.jab_in  = I_JABBER;
    assign acc.anc_in  = I_AN_DONE && ctrl_r[`PBMR_CTRL_AN_BIT];

    pbmr_latch u_latch (
        .clk   (I_MCLK),
        .rst_n (I_RST_N),
        .acc   (acc.lat_mp)
    );

    pbmr_ident #(
        .OUI_HI (OUI_HI),
        .OUI_LO (OUI_LO),
        .MODEL  (MODEL),
        .REV    (REV)
    ) u_ident (
        .clk   (I_MCLK),
        .rst_n (I_RST_N),
        .acc   (acc.id_mp)
    );

    // status word: fixed capabilities plus live and latched bits
    always_comb begin
        stat_word                      = `PBMR_STAT_FIXED;
        stat_word[`PBMR_STAT_ANC_BIT]  = acc.anc_q;
        stat_word[`PBMR_STAT_RF_BIT]   = acc.rf_lat;
        stat_word[`PBMR_STAT_LINK_BIT] = acc.link_lat;
        stat_word[`PBMR_STAT_JAB_BIT]  = acc.jab_lat;
    end

    // control, advertisement and read path
    always_comb begin
        ctrl_nxt   = ctrl_r;
        adv_nxt    = adv_r;
        srst_nxt   = 1'b0;
        anrs_nxt   = 1'b0;
        rdata_nxt  = rdata_r;
        rvalid_nxt = I_REG_RD;
        if (srst_r) begin
            ctrl_nxt = `PBMR_CTRL_RESET;
            adv_nxt  = `PBMR_ADV_RESET;
        end else begin
            if (wr_ctrl) begin
                if (I_REG_WDATA[`PBMR_CTRL_RST_BIT]) begin
                    srst_nxt = 1'b1;
                end else begin
                    ctrl_nxt = I_REG_WDATA & `PBMR_CTRL_WMASK;
                    anrs_nxt = I_REG_WDATA[`PBMR_CTRL_ANRS_BIT];
                end
            end
            if (wr_adv) begin
                adv_nxt = I_REG_WDATA & `PBMR_ADV_WMASK;
            end
        end
        // manual speed and duplex only when negotiation is off
        spd_nxt = ctrl_r[`PBMR_CTRL_AN_BIT] ? I_AN_SPEED_100
                                           : ctrl_r[`PBMR_CTRL_SPD_BIT];
        dup_nxt = ctrl_r[`PBMR_CTRL_AN_BIT] ? I_AN_FULL_DUPLEX
                                           : ctrl_r[`PBMR_CTRL_DUP_BIT];
        if (I_REG_RD) begin
            unique case (I_REG_INDEX)
                `PBMR_IDX_CTRL:  rdata_nxt = ctrl_r;
                `PBMR_IDX_STAT:  rdata_nxt = stat_word;
                `PBMR_IDX_ID_HI: rdata_nxt = acc.id_hi;
                `PBMR_IDX_ID_LO: rdata_nxt = acc.id_lo;
                `PBMR_IDX_ADV:   rdata_nxt = adv_r;
                default:         rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ctrl_r   <= `PBMR_CTRL_RESET;
            adv_r    <= `PBMR_ADV_RESET;
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
            srst_r   <= 1'b0;
            anrs_r   <= 1'b0;
            spd_r    <= 1'b1;
            dup_r    <= 1'b0;
        end else begin
            ctrl_r   <= ctrl_nxt;
            adv_r    <= adv_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            srst_r   <= srst_nxt;
            anrs_r   <= anrs_nxt;
            spd_r    <= spd_nxt;
            dup_r    <= dup_nxt;
        end
    end

    assign O_REG_RDATA   = rdata_r;
    assign O_REG_RVALID  = rvalid_r;
    assign O_SOFT_RESET  = srst_r;
    assign O_AN_RESTART  = anrs_r;
    assign O_LOOPBACK    = ctrl_r[`PBMR_CTRL_LOOP_BIT];
    assign O_AN_ENABLE   = ctrl_r[`PBMR_CTRL_AN_BIT];
    assign O_POWER_DOWN  = ctrl_r[`PBMR_CTRL_PDN_BIT];
    assign O_COL_TEST    = ctrl_r[`PBMR_CTRL_COLT_BIT];
    assign O_SPEED_100   = spd_r;
    assign O_FULL_DUPLEX = dup_r;
    assign O_ADVERT      = adv_r;

    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_RST_N);

    property p_pulse_once(trig, pulse);
        trig |=> pulse ##1 !pulse;
    endproperty

    a_srst_pulse_once: assert property (
        p_pulse_once(wr_ctrl && I_REG_WDATA[`PBMR_CTRL_RST_BIT] && !srst_r, O_SOFT_RESET))
        else $error("soft reset did not pulse for one cycle");
    a_srst_defaults: assert property (
        O_SOFT_RESET |=> ctrl_r == `PBMR_CTRL_RESET && adv_r == `PBMR_ADV_RESET)
        else $error("soft reset did not restore defaults");
    a_srst_reads_zero: assert property (
        O_REG_RVALID && $past(I_REG_INDEX) == `PBMR_IDX_CTRL
        |-> !O_REG_RDATA[`PBMR_CTRL_RST_BIT] && !O_REG_RDATA[`PBMR_CTRL_ANRS_BIT])
        else $error("self clearing control bit read as one");
    a_loop_follow_write: assert property (
        wr_ctrl && !srst_r && !I_REG_WDATA[`PBMR_CTRL_RST_BIT]
        |=> O_LOOPBACK == $past(I_REG_WDATA[`PBMR_CTRL_LOOP_BIT])
            && O_POWER_DOWN == $past(I_REG_WDATA[`PBMR_CTRL_PDN_BIT]))
        else $error("loopback or power down did not follow write");
    a_speed_forced_sel: assert property (
        !O_AN_ENABLE |=> O_SPEED_100 == $past(ctrl_r[`PBMR_CTRL_SPD_BIT]))
        else $error("forced speed not applied");
    a_speed_an_override: assert property (
        O_AN_ENABLE |=> O_SPEED_100 == $past(I_AN_SPEED_100)
                        && O_FULL_DUPLEX == $past(I_AN_FULL_DUPLEX))
        else $error("negotiated result did not override manual choice");
    a_duplex_forced_sel: assert property (
        !O_AN_ENABLE |=> O_FULL_DUPLEX == $past(ctrl_r[`PBMR_CTRL_DUP_BIT]))
        else $error("forced duplex not applied");
    a_anrs_pulse_once: assert property (
        p_pulse_once(wr_ctrl && !srst_r && !I_REG_WDATA[`PBMR_CTRL_RST_BIT]
                     && I_REG_WDATA[`PBMR_CTRL_ANRS_BIT], O_AN_RESTART))
        else $error("negotiation restart did not pulse for one cycle");
    a_coltest_follow: assert property (
        wr_ctrl && !srst_r && !I_REG_WDATA[`PBMR_CTRL_RST_BIT]
        |=> O_COL_TEST == $past(I_REG_WDATA[`PBMR_CTRL_COLT_BIT]))
        else $error("collision test did not follow write");
    a_stat_fixed_bits: assert property (
        O_REG_RVALID && $past(I_REG_INDEX) == `PBMR_IDX_STAT
        |-> (O_REG_RDATA & `PBMR_STAT_FMASK) == `PBMR_STAT_FIXED
            && O_REG_RDATA[10:6] == 5'h00)
        else $error("status fixed bits wrong");
    a_ctrl_rsvd_zero: assert property (
        O_REG_RVALID && $past(I_REG_INDEX) == `PBMR_IDX_CTRL
        |-> O_REG_RDATA[6:0] == 7'h00 && !O_REG_RDATA[10])
        else $error("reserved control bits not zero");
    a_adv_write_mask: assert property (
        wr_adv && !srst_r |=> O_ADVERT == ($past(I_REG_WDATA) & `PBMR_ADV_WMASK))
        else $error("advertisement write not stored");
    a_link_read_path: assert property (
        !I_LINK_UP ##1 (I_REG_RD && I_REG_INDEX == `PBMR_IDX_STAT)
        |=> !O_REG_RDATA[`PBMR_STAT_LINK_BIT])
        else $error("link loss not reported on read");

    // read port timing and unmapped indices
    a_rvalid_after_rd: assert property (
        I_REG_RD |=> O_REG_RVALID)
        else $error("read answer missing one cycle after strobe");
    a_rvalid_no_rd: assert property (
        !I_REG_RD |=> !O_REG_RVALID)
        else $error("read answer without a strobe");
    a_rdata_hold: assert property (
        !I_REG_RD |=> $stable(O_REG_RDATA))
        else $error("read data changed without a read");
    a_unmapped_rd_zero: assert property (
        I_REG_RD && I_REG_INDEX > `PBMR_IDX_ADV |=> O_REG_RDATA == 16'h0000)
        else $error("unmapped index did not read zero");
    a_unmapped_wr_ignored: assert property (
        I_REG_WR && I_REG_INDEX > `PBMR_IDX_ADV && !srst_r
        |=> $stable(ctrl_r) && $stable(adv_r))
        else $error("unmapped write changed a register");
    a_adv_read_path: assert property (
        O_REG_RVALID && $past(I_REG_INDEX) == `PBMR_IDX_ADV
        |-> O_REG_RDATA == $past(O_ADVERT))
        else $error("advertisement read did not return its register");

    // soft reset details and hard reset defaults
    a_srst_idle: assert property (
        !wr_ctrl |=> !O_SOFT_RESET)
        else $error("soft reset pulsed without a control write");
    a_srst_write_alone: assert property (
        wr_ctrl && I_REG_WDATA[`PBMR_CTRL_RST_BIT] && !srst_r
        |=> $stable(ctrl_r) && !O_AN_RESTART)
        else $error("soft reset write changed other control bits");
    a_srst_clears_latch: assert property (
        acc.sreset && !I_REMOTE_FAULT && !I_JABBER |=> !acc.rf_lat && !acc.jab_lat)
        else $error("soft reset left a fault latch set");
    a_srst_keeps_id: assert property (
        O_SOFT_RESET && !I_REG_WR |=> $stable(acc.id_hi) && $stable(acc.id_lo))
        else $error("identifier lost over soft reset");
    a_srst_ctrl_levels: assert property (
        O_SOFT_RESET |=> O_AN_ENABLE && !O_LOOPBACK && !O_POWER_DOWN)
        else $error("control levels not at defaults after soft reset");
    a_reset_defaults: assert property (
        $rose(I_RST_N) |-> ctrl_r == `PBMR_CTRL_RESET && adv_r == `PBMR_ADV_RESET)
        else $error("register defaults wrong after reset");

    // status bits, identifier low read and reserved advertisement bit
    a_anc_follows: assert property (
        I_AN_DONE && O_AN_ENABLE |=> acc.anc_q)
        else $error("negotiation complete not shown");
    a_anc_off: assert property (
        !I_AN_DONE || !O_AN_ENABLE |=> !acc.anc_q)
        else $error("negotiation complete shown while not done");
    a_rf_event_sets: assert property (
        I_REMOTE_FAULT |=> acc.rf_lat)
        else $error("remote fault latch did not set");
    a_rf_read_clear: assert property (
        acc.rd_stat && !I_REMOTE_FAULT |=> !acc.rf_lat)
        else $error("remote fault latch not cleared by read");
    a_jab_read_clear: assert property (
        acc.rd_stat && !I_JABBER |=> !acc.jab_lat)
        else $error("jabber latch not cleared by read");
    a_link_read_rise: assert property (
        acc.rd_stat && I_LINK_UP |=> acc.link_lat)
        else $error("link status did not return after read");
    a_link_read_value: assert property (
        O_REG_RVALID && $past(I_REG_INDEX) == `PBMR_IDX_STAT
        |-> O_REG_RDATA[`PBMR_STAT_LINK_BIT] == $past(acc.link_lat))
        else $error("link status read differs from its latch");
    a_id_read_path: assert property (
        O_REG_RVALID && $past(I_REG_INDEX) == `PBMR_IDX_ID_LO
        |-> O_REG_RDATA == $past(acc.id_lo))
        else $error("identifier read did not return its register");
    a_adv_rsvd_zero: assert property (
        !O_ADVERT[14])
        else $error("reserved advertisement bit set");

    // controls
    a_anrs_idle: assert property (
        !wr_ctrl |=> !O_AN_RESTART)
        else $error("negotiation restart without a control write");
    a_an_en_follow: assert property (
        wr_ctrl && !srst_r && !I_REG_WDATA[`PBMR_CTRL_RST_BIT]
        |=> O_AN_ENABLE == $past(I_REG_WDATA[`PBMR_CTRL_AN_BIT]))
        else $error("negotiation enable did not follow write");
    a_pdn_follow: assert property (
        wr_ctrl && !srst_r && !I_REG_WDATA[`PBMR_CTRL_RST_BIT]
        |=> O_POWER_DOWN == $past(I_REG_WDATA[`PBMR_CTRL_PDN_BIT]))
        else $error("power down did not follow write");

    c_soft_reset: cover property (wr_ctrl && I_REG_WDATA[`PBMR_CTRL_RST_BIT] ##2 !O_SOFT_RESET);
    c_an_restart: cover property (O_AN_RESTART);
    c_link_loss_read: cover property (
        !I_LINK_UP ##1 I_LINK_UP [*2] ##0 acc.rd_stat ##1 O_REG_RVALID);
    c_adv_write: cover property (wr_adv ##1 O_ADVERT != `PBMR_ADV_RESET);
    c_power_down: cover property (wr_ctrl ##1 O_POWER_DOWN);
endmodule
`default_nettype wire

//--- bench/pbmr_mac_model.sv
`timescale 1ns/100ps
`default_nettype none
module pbmr_mac_model
    import pbmr_pkg::*;
(
    // clock
    input  wire logic        clk,
    // index access toward the registers
    output var  logic [4:0]  o_index,
    output var  logic        o_wr,
    output var  logic        o_rd,
    output var  logic [15:0] o_wdata,
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_rvalid
);
    initial begin
        o_index = 5'h1f;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_wdata = 16'h5a5a;
    end

    // every access selects a register by index
    task automatic wr_reg(input pbmr_index_t idx, input pbmr_word_t data);
        @(posedge clk);
        o_index <= idx;
        o_wdata <= data;
        o_wr    <= 1'b1;
        @(posedge clk);
        o_wr    <= 1'b0;
        o_index <= ~idx;
        o_wdata <= ~data;
    endtask

    task automatic rd_reg(input pbmr_index_t idx, output pbmr_word_t data, output logic ok);
        int n;
        ok   = 1'b0;
        data = 16'h0000;
        @(posedge clk);
        o_index <= idx;
        o_rd    <= 1'b1;
        @(posedge clk);
        o_rd    <= 1'b0;
        o_index <= ~idx;
        // answer expected one cycle after the strobe edge
        for (n = 0; n < 4; n++) begin
            @(posedge clk);
            if (i_rvalid === 1'b1) begin
                ok   = 1'b1;
                data = i_rdata;
                break;
            end
        end
    endtask
endmodule
`default_nettype wire

//--- bench/tb_phy_basic_management_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "pbmr_map.svh"
module tb_phy_basic_management_regs
    import pbmr_pkg::*;
;
    logic mclk, rst_n, wr, rd, rvalid, link, anc, rf, jab, an_spd, an_dup;
    logic srst, loop, spd, dup, an_en, an_rs, pdn, colt;
    logic [4:0]  idx;
    pbmr_word_t  wdata, rdata, advert;
    int n_errors, check_count, n_srst, n_anrs, k;

    phy_basic_management_regs i_phy_basic_management_regs (
        .I_MCLK(mclk), .I_RST_N(rst_n), .I_REG_INDEX(idx), .I_REG_WR(wr),
        .I_REG_RD(rd), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
        .I_LINK_UP(link), .I_AN_DONE(anc), .I_REMOTE_FAULT(rf), .I_JABBER(jab),
        .I_AN_SPEED_100(an_spd), .I_AN_FULL_DUPLEX(an_dup), .O_SOFT_RESET(srst),
        .O_LOOPBACK(loop), .O_SPEED_100(spd), .O_FULL_DUPLEX(dup), .O_AN_ENABLE(an_en),
        .O_AN_RESTART(an_rs), .O_POWER_DOWN(pdn), .O_COL_TEST(colt), .O_ADVERT(advert));

    pbmr_mac_model i_pbmr_mac_model (
        .clk(mclk), .o_index(idx), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
        .i_rdata(rdata), .i_rvalid(rvalid));

    initial mclk = 1'b0;
    always #2 mclk = ~mclk;

    // pulse counters for the self-clearing controls
    always @(posedge mclk) begin
        if (srst === 1'b1) n_srst++;
        if (an_rs === 1'b1) n_anrs++;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk16(input pbmr_word_t got, input pbmr_word_t exp, input string m);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string m);
        chk16({15'h0, got}, {15'h0, exp}, m);
    endtask

    task automatic rd_chk(input pbmr_index_t i, input pbmr_word_t exp, input pbmr_word_t msk);
        pbmr_word_t d;
        logic ok;
        i_pbmr_mac_model.rd_reg(i, d, ok);
        chk1(ok, 1'b1, "read answer");
        chk16(d & msk, exp, "read data");
    endtask

    task automatic wr_reg(input pbmr_index_t i, input pbmr_word_t d);
        i_pbmr_mac_model.wr_reg(i, d);
        repeat (3) @(posedge mclk);
    endtask

    task automatic t_reset_vals;
        rd_chk(`PBMR_IDX_CTRL, 16'h3000, 16'hffff);
        rd_chk(`PBMR_IDX_STAT, 16'h7809, 16'hffff);
        rd_chk(`PBMR_IDX_STAT, 16'h0009, 16'h0009);
        rd_chk(`PBMR_IDX_ID_HI, 16'h1234, 16'hffff);
        rd_chk(`PBMR_IDX_ID_LO, 16'ha851, 16'hffff);
        rd_chk(`PBMR_IDX_ADV, 16'h01e1, 16'hffff);
        rd_chk(`PBMR_IDX_ADV, 16'h0001, 16'h801f);
        chk1(loop, 1'b0, "loopback");
        chk1(an_en, 1'b1, "negotiation on");
        chk1(spd, 1'b0, "negotiated speed");
        chk1(dup, 1'b1, "negotiated duplex");
        chk16(advert, 16'h01e1, "advert out");
    endtask

    task automatic t_ctrl;
        k = n_anrs;
        wr_reg(`PBMR_IDX_CTRL, 16'h4200);
        chk16(16'(n_anrs - k), 16'h0001, "restart pulse");
        chk1(loop, 1'b1, "loopback");
        chk1(an_en, 1'b0, "negotiation off");
        chk1(spd, 1'b0, "manual 10");
        rd_chk(`PBMR_IDX_CTRL, 16'h4000, 16'hffff);
        wr_reg(`PBMR_IDX_CTRL, 16'h2100);
        chk1(spd, 1'b1, "manual 100");
        chk1(dup, 1'b1, "manual full");
        wr_reg(`PBMR_IDX_CTRL, 16'h2980);
        chk1(pdn, 1'b1, "power down");
        chk1(colt, 1'b1, "col test");
        rd_chk(`PBMR_IDX_CTRL, 16'h2980, 16'hffff);
        wr_reg(`PBMR_IDX_CTRL, 16'h047f);
        rd_chk(`PBMR_IDX_CTRL, 16'h0000, 16'hffff);
        chk1(pdn, 1'b0, "power up");
        chk1(colt, 1'b0, "col test off");
        chk1(dup, 1'b0, "manual half");
        wr_reg(`PBMR_IDX_CTRL, 16'h3000);
        chk1(spd, 1'b0, "speed bit ignored");
        chk1(dup, 1'b1, "duplex bit ignored");
        an_spd <= 1'b1;
        an_dup <= 1'b0;
        repeat (2) @(posedge mclk);
        chk1(spd, 1'b1, "negotiated 100");
        chk1(dup, 1'b0, "negotiated half");
    endtask

    task automatic t_soft;
        wr_reg(`PBMR_IDX_ADV, 16'h0c00);
        wr_reg(`PBMR_IDX_ID_HI, 16'hbeef);
        wr_reg(`PBMR_IDX_CTRL, 16'h4000);
        k = n_srst;
        wr_reg(`PBMR_IDX_CTRL, 16'h8000);
        chk16(16'(n_srst - k), 16'h0001, "soft reset pulse");
        rd_chk(`PBMR_IDX_CTRL, 16'h3000, 16'hffff);
        rd_chk(`PBMR_IDX_ADV, 16'h01e1, 16'hffff);
        rd_chk(`PBMR_IDX_ID_HI, 16'hbeef, 16'hffff);
    endtask

    task automatic t_status;
        link <= 1'b1;
        anc  <= 1'b1;
        rd_chk(`PBMR_IDX_STAT, 16'h0000, 16'h0004);
        rd_chk(`PBMR_IDX_STAT, 16'h0004, 16'h0004);
        rd_chk(`PBMR_IDX_STAT, 16'h0020, 16'h0020);
        @(posedge mclk) link <= 1'b0;
        rd_chk(`PBMR_IDX_STAT, 16'h0000, 16'h0004);
        link <= 1'b1;
        rd_chk(`PBMR_IDX_STAT, 16'h0000, 16'h0004);
        rd_chk(`PBMR_IDX_STAT, 16'h0004, 16'h0004);
        @(posedge mclk) begin
            rf  <= 1'b1;
            jab <= 1'b1;
        end
        @(posedge mclk) begin
            rf  <= 1'b0;
            jab <= 1'b0;
        end
        repeat (3) @(posedge mclk);
        rd_chk(`PBMR_IDX_STAT, 16'h0012, 16'h0012);
        rd_chk(`PBMR_IDX_STAT, 16'h0000, 16'h0012);
        wr_reg(`PBMR_IDX_CTRL, 16'h0000);
        rd_chk(`PBMR_IDX_STAT, 16'h0000, 16'h0020);
    endtask

    task automatic t_adv;
        for (int p = 0; p < 4; p++) begin
            wr_reg(`PBMR_IDX_ADV, {4'h0, 2'(p), 10'h001});
            rd_chk(`PBMR_IDX_ADV, {4'h0, 2'(p), 10'h000}, 16'h0c00);
            chk16({14'h0, advert[11:10]}, 16'(p), "pause out");
        end
        wr_reg(`PBMR_IDX_ADV, 16'hffff);
        rd_chk(`PBMR_IDX_ADV, 16'hbfff, 16'hffff);
        chk16(advert, 16'hbfff, "advert out");
        wr_reg(5'h05, 16'h0000);
        rd_chk(5'h05, 16'h0000, 16'hffff);
        rd_chk(5'h1f, 16'h0000, 16'hffff);
        rd_chk(`PBMR_IDX_ADV, 16'hbfff, 16'hffff);
    endtask

    initial begin
        n_errors = 0;
        check_count = 0;
        n_srst = 0;
        n_anrs = 0;
        rst_n = 1'b0;
        link = 1'b0;
        anc = 1'b0;
        rf = 1'b0;
        jab = 1'b0;
        an_spd = 1'b0;
        an_dup = 1'b1;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset_vals();
        t_ctrl();
        t_soft();
        t_status();
        t_adv();
        end_sim();
    end

    // watchdog well beyond the expected run
    initial begin
        #(4 * 20000);
        n_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
